// file: core/tmr_top.sv
// Purpose: 16-bit timer with normal, clear-on-match and fast pwm
// Assumes: one clock, software on the plain register port
// Notes: dual-slope modes count as normal
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`include "tmr_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tmr_top (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// register port
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	// interrupt service acknowledge per flag
	input wire logic [3:0] FLAG_ACK,
	// flag levels
	output logic [3:0] FLAGS,
	// compare output pins
	output logic OC_A,
	output logic OC_A_OE_N,
	output logic OC_B,
	output logic OC_B_OE_N
);
	import tmr_pkg::*;

	logic [15:0] ctrl;
	logic [15:0] count;
	logic [15:0] cmpa;
	logic [15:0] cmpb;
	logic [15:0] bufa;
	logic [15:0] bufb;
	logic [15:0] captop;
	logic [3:0] flags;
	logic [1:0] dir;
	logic [9:0] psc;
	logic tick;
	logic block;
	logic oc_a;
	logic oc_b;
	tmr_mode_t mode;
	tmr_act_t act_a;
	tmr_act_t act_b;
	logic [2:0] psc_sel;
	logic is_pwm;
	logic is_ctc;
	logic [15:0] top;
	logic at_top;
	logic at_max;
	logic match_a;
	logic match_b;
	logic wrap_top;
	logic w_ctrl;
	logic w_count;
	logic w_cmpa;
	logic w_cmpb;
	logic w_cap;
	logic w_flags;
	logic w_dir;
	logic [15:0] wmask;
	logic [3:0] next_set;

	// fixed top mask applied to compare writes
	function automatic logic [15:0] top_mask(input tmr_mode_t m);
		unique case (m)
			TMR_FP8: top_mask = `TMR_TOP8;
			TMR_FP9: top_mask = `TMR_TOP9;
			TMR_FP10: top_mask = `TMR_TOP10;
			default: top_mask = `TMR_MAX;
		endcase
	endfunction

	// output action at a compare match
	// toggle is honoured in pwm only where the caller allows it (mode 15, channel a)
	function automatic logic act_match(input tmr_act_t a, input logic cur,
		input logic pwm, input logic tog_ok);
		unique case (a)
			TMR_ACT_NONE: act_match = cur;
			TMR_ACT_TOG: act_match = (pwm && !tog_ok) ? cur : ~cur;
			TMR_ACT_CLR: act_match = 1'b0;
			TMR_ACT_SET: act_match = 1'b1;
		endcase
	endfunction

	// output level forced at bottom in pwm
	function automatic logic act_bottom(input tmr_act_t a, input logic cur);
		unique case (a)
			TMR_ACT_CLR: act_bottom = 1'b1;
			TMR_ACT_SET: act_bottom = 1'b0;
			default: act_bottom = cur;
		endcase
	endfunction

	// field decode
	// control bits 15:11 are not stored and read as zero
	assign mode = tmr_mode_t'(ctrl[`TMR_MODE_LSB +: 4]);
	assign act_a = tmr_act_t'(ctrl[`TMR_ACTA_LSB +: 2]);
	assign act_b = tmr_act_t'(ctrl[`TMR_ACTB_LSB +: 2]);
	assign psc_sel = ctrl[`TMR_PSC_LSB +: 3];

	// address decode
	assign w_ctrl = WR && (ADDR == `TMR_CTRL);
	assign w_count = WR && (ADDR == `TMR_COUNT);
	assign w_cmpa = WR && (ADDR == `TMR_CMPA);
	assign w_cmpb = WR && (ADDR == `TMR_CMPB);
	assign w_cap = WR && (ADDR == `TMR_CAPTOP);
	assign w_flags = WR && (ADDR == `TMR_FLAGS);
	assign w_dir = WR && (ADDR == `TMR_DIR);

	// mode classes; only the mode field shapes counting
	assign is_pwm = (mode == TMR_FP8) || (mode == TMR_FP9)
		|| (mode == TMR_FP10) || (mode == TMR_FP_C)
		|| (mode == TMR_FP_A);
	assign is_ctc = (mode == TMR_CTC_A) || (mode == TMR_CTC_C);
	assign wmask = top_mask(mode);

	// top source select
	always_comb begin
		unique case (mode)
			TMR_CTC_A: top = cmpa;
			TMR_FP_A: top = cmpa;
			TMR_CTC_C: top = captop;
			TMR_FP_C: top = captop;
			TMR_FP8: top = `TMR_TOP8;
			TMR_FP9: top = `TMR_TOP9;
			TMR_FP10: top = `TMR_TOP10;
			default: top = `TMR_MAX;
		endcase
	end

	// top and max detection on a tick
	assign at_max = tick && (count == `TMR_MAX);
	assign wrap_top = (is_ctc || is_pwm) && (count == top);
	assign at_top = tick && wrap_top;
	// a counter write masks the next tick's matches
	assign match_a = tick && !block && (count == cmpa);
	assign match_b = tick && !block && (count == cmpb);

	// prescaler: one tick every n clocks, stopped on selects 0, 6 and 7
	// held at zero while stopped, so a restart gives a full first tick period
	always_ff @(posedge CLK) begin
		if (RST) begin
			psc <= 10'h000;
		end else if (tick || psc_sel == 3'h0 || psc_sel > 3'h5) begin
			psc <= 10'h000;
		end else begin
			psc <= psc + 10'h001;
		end
	end

	// tick is a one-clock enable, never a derived clock
	always_comb begin
		unique case (psc_sel)
			3'h1: tick = 1'b1;
			3'h2: tick = (psc == `TMR_DIV8);
			3'h3: tick = (psc == `TMR_DIV64);
			3'h4: tick = (psc == `TMR_DIV256);
			3'h5: tick = (psc == `TMR_DIV1024);
			default: tick = 1'b0;
		endcase
	end

	// control register
	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl <= `TMR_CTRL_RST;
		end else if (w_ctrl) begin
			ctrl <= {5'h00, WDATA[10:0]};
		end
	end

	// pin direction bits
	always_ff @(posedge CLK) begin
		if (RST) begin
			dir <= 2'h0;
		end else if (w_dir) begin
			dir <= WDATA[1:0];
		end
	end

	// counter: software write wins over counting
	// a top below the count is missed; the count runs through max and wraps
	// the clear at top is not blocked by a counter write, only compare and capture flags and match actions
	always_ff @(posedge CLK) begin
		if (RST) begin
			count <= `TMR_ZERO;
		end else if (w_count) begin
			count <= WDATA;
		end else if (at_top) begin
			count <= `TMR_ZERO;
		end else if (tick) begin
			count <= count + 16'h0001;
		end
	end

	// match block lasts until the next tick, even when stopped
	always_ff @(posedge CLK) begin
		if (RST) begin
			block <= 1'b0;
		end else if (w_count) begin
			block <= 1'b1;
		end else if (tick) begin
			block <= 1'b0;
		end
	end

	// capture register doubles as top, never buffered
	always_ff @(posedge CLK) begin
		if (RST) begin
			captop <= `TMR_ZERO;
		end else if (w_cap) begin
			captop <= WDATA;
		end
	end

	// compare buffers hold the last software write
	// outside pwm they shadow the active value so reads stay consistent
	always_ff @(posedge CLK) begin
		if (RST) begin
			bufa <= `TMR_ZERO;
			bufb <= `TMR_ZERO;
		end else begin
			if (w_cmpa) begin
				bufa <= WDATA & wmask;
			end
			if (w_cmpb) begin
				bufb <= WDATA & wmask;
			end
		end
	end

	// active compares: direct outside pwm, loaded at top in pwm
	// a mode change does not copy the buffer; software rewrites compares after it
	always_ff @(posedge CLK) begin
		if (RST) begin
			cmpa <= `TMR_ZERO;
			cmpb <= `TMR_ZERO;
		end else if (is_pwm) begin
			if (at_top) begin
				cmpa <= bufa;
				cmpb <= bufb;
			end
		end else begin
			if (w_cmpa) begin
				cmpa <= WDATA & wmask;
			end
			if (w_cmpb) begin
				cmpb <= WDATA & wmask;
			end
		end
	end

	// flag set sources for this cycle
	// overflow marks top in pwm and the roll from max elsewhere
	// the capture flag stands for top only in the two capture-top modes
	always_comb begin
		next_set = 4'h0;
		if (is_pwm) begin
			next_set[`TMR_F_OVF] = at_top;
		end else begin
			next_set[`TMR_F_OVF] = at_max;
		end
		next_set[`TMR_F_CMPA] = match_a;
		next_set[`TMR_F_CMPB] = match_b;
		if (mode == TMR_CTC_C || mode == TMR_FP_C) begin
			next_set[`TMR_F_CAP] = at_top && !block;
		end
	end

	// sticky flags; a set in the clearing cycle wins
	always_ff @(posedge CLK) begin
		if (RST) begin
			flags <= 4'h0;
		end else begin
			flags <= next_set | (flags & ~FLAG_ACK
				& ~(w_flags ? WDATA[3:0] : 4'h0));
		end
	end

	// channel a output state
	// at top the bottom action follows any match action of the same tick,
	// so a compare equal to top gives a constant level unless channel a toggles in mode 15
	always_ff @(posedge CLK) begin
		if (RST) begin
			oc_a <= 1'b0;
		end else if (is_pwm && at_top) begin
			oc_a <= act_bottom(act_a, match_a
				? act_match(act_a, oc_a, 1'b1, mode == TMR_FP_A) : oc_a);
		end else if (match_a) begin
			oc_a <= act_match(act_a, oc_a, is_pwm,
				mode == TMR_FP_A);
		end
	end

	// channel b output state; no toggle in pwm
	// toggle on channel b acts only in normal and clear-on-match modes
	always_ff @(posedge CLK) begin
		if (RST) begin
			oc_b <= 1'b0;
		end else if (is_pwm && at_top) begin
			oc_b <= act_bottom(act_b, oc_b);
		end else if (match_b) begin
			oc_b <= act_match(act_b, oc_b, is_pwm, 1'b0);
		end
	end

	// pin drivers, registered; enable is active low
	// pins lag the internal state by one clock; a zero action releases the pin
	always_ff @(posedge CLK) begin
		if (RST) begin
			OC_A <= 1'b0;
			OC_B <= 1'b0;
			OC_A_OE_N <= 1'b1;
			OC_B_OE_N <= 1'b1;
		end else begin
			OC_A <= oc_a;
			OC_B <= oc_b;
			OC_A_OE_N <= !(dir[0] && act_a != TMR_ACT_NONE);
			OC_B_OE_N <= !(dir[1] && act_b != TMR_ACT_NONE);
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	// pwm reads return the buffer, the value software last wrote
	always_ff @(posedge CLK) begin
		if (RST) begin
			RDATA <= 16'h0000;
		end else if (RD) begin
			unique case (ADDR)
				`TMR_CTRL: RDATA <= ctrl;
				`TMR_COUNT: RDATA <= count;
				`TMR_CMPA: RDATA <= is_pwm ? bufa : cmpa;
				`TMR_CMPB: RDATA <= is_pwm ? bufb : cmpb;
				`TMR_CAPTOP: RDATA <= captop;
				`TMR_FLAGS: RDATA <= {12'h000, flags};
				`TMR_DIR: RDATA <= {14'h0, dir};
				default: RDATA <= 16'h0000;
			endcase
		end else begin
			RDATA <= 16'h0000;
		end
	end

	assign FLAGS = flags;
endmodule
`default_nettype wire

// file: core/tmr_regs.svh
// Purpose: offsets, fields, resets and timing of the timer
// Assumes: word index addressing on the plain register port
// Notes: definitions only
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
// register indices
`define TMR_CTRL 4'h0
`define TMR_COUNT 4'h1
`define TMR_CMPA 4'h2
`define TMR_CMPB 4'h3
`define TMR_CAPTOP 4'h4
`define TMR_FLAGS 4'h5
`define TMR_DIR 4'h6
// control fields
`define TMR_MODE_LSB 0
`define TMR_ACTA_LSB 4
`define TMR_ACTB_LSB 6
`define TMR_PSC_LSB 8
// flag bits
`define TMR_F_OVF 0
`define TMR_F_CMPA 1
`define TMR_F_CMPB 2
`define TMR_F_CAP 3
// reset values
`define TMR_CTRL_RST 16'h0000
`define TMR_ZERO 16'h0000
`define TMR_MAX 16'hffff
// fixed tops
`define TMR_TOP8 16'h00ff
`define TMR_TOP9 16'h01ff
`define TMR_TOP10 16'h03ff
// prescale terminal counts, each one less than its divisor
`define TMR_DIV8 10'h007
`define TMR_DIV64 10'h03f
`define TMR_DIV256 10'h0ff
`define TMR_DIV1024 10'h3ff
`endif

// file: core/tmr_pkg.sv
// Purpose: types of the timer
// Assumes: nothing
// Notes: waveform mode codes and output actions
package tmr_pkg;
	typedef logic [3:0] tmr_mode_t;
	localparam tmr_mode_t TMR_NORMAL = 4'h0;
	localparam tmr_mode_t TMR_CTC_A = 4'h4;
	localparam tmr_mode_t TMR_FP8 = 4'h5;
	localparam tmr_mode_t TMR_FP9 = 4'h6;
	localparam tmr_mode_t TMR_FP10 = 4'h7;
	localparam tmr_mode_t TMR_CTC_C = 4'hc;
	localparam tmr_mode_t TMR_FP_C = 4'he;
	localparam tmr_mode_t TMR_FP_A = 4'hf;
	typedef enum logic [1:0] {
		TMR_ACT_NONE = 2'h0,
		TMR_ACT_TOG = 2'h1,
		TMR_ACT_CLR = 2'h2,
		TMR_ACT_SET = 2'h3
	} tmr_act_t;
endpackage

// file: tb/tmr_monitor.sv
// Purpose: port checker for the timer
// Assumes: register indices and fields of tmr_regs.svh
// Notes: control and direction are shadowed from bus writes
`include "tmr_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tmr_monitor (
	// clock, reset and register port
	input wire logic CLK,
	input wire logic RST,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	// flags and compare pins
	input wire logic [3:0] FLAG_ACK,
	input wire logic [3:0] FLAGS,
	input wire logic OC_A,
	input wire logic OC_A_OE_N,
	input wire logic OC_B,
	input wire logic OC_B_OE_N
);
	logic [15:0] ctrl;
	logic [1:0] dir;
	logic stop;
	// shadow copies, since the checker cannot see inside
	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl <= `TMR_CTRL_RST;
			dir <= 2'h0;
		end else if (WR && ADDR == `TMR_CTRL) begin
			ctrl <= WDATA;
		end else if (WR && ADDR == `TMR_DIR) begin
			dir <= WDATA[1:0];
		end
	end
	// codes 0, 6 and 7 give no ticks
	assign stop = ctrl[10:8] == 3'h0 || ctrl[10:8] > 3'h5;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	AST_RDATA_SLOT: assert property (!$past(RD) |-> RDATA == 16'h0)
		else $error("read data outside its slot");
	AST_UNMAPPED: assert property (RD && ADDR > `TMR_DIR |=> RDATA == 16'h0)
		else $error("unmapped read not zero");
	AST_FLAG_STICKY: assert property ((~FLAGS & $past(FLAGS) & ~$past(FLAG_ACK) &
		~($past(WR && ADDR == `TMR_FLAGS) ? $past(WDATA[3:0]) : 4'h0)) == 4'h0)
		else $error("flag cleared without ack");
	AST_FLAGS_READ: assert property (RD && ADDR == `TMR_FLAGS |=>
		RDATA == {12'h0, $past(FLAGS)}) else $error("flag read mismatch");
	AST_OE_A: assert property (OC_A_OE_N == !($past(dir[0]) && $past(ctrl[5:4]) != 2'h0))
		else $error("pin a enable wrong");
	AST_OE_B: assert property (OC_B_OE_N == !($past(dir[1]) && $past(ctrl[7:6]) != 2'h0))
		else $error("pin b enable wrong");
	AST_ACT0_HOLD: assert property ($past(ctrl[5:4] == 2'h0) && $past(ctrl[5:4] == 2'h0, 2) &&
		$past(ctrl[5:4] == 2'h0, 3) |-> $stable(OC_A)) else $error("idle output moved");
	AST_COUNT_WR_BLOCK: assert property (WR && ADDR == `TMR_COUNT |-> ##2
		!$rose(FLAGS[1]) && !$rose(FLAGS[2])) else $error("match after count write");
	AST_STOP_NO_FLAG: assert property ($past(stop) && $past(stop, 2) && $past(stop, 3) |->
		(FLAGS & ~$past(FLAGS)) == 4'h0) else $error("flag set while stopped");
	COV_OVF: cover property ($rose(FLAGS[0]));
	COV_OC_A: cover property ($rose(OC_A));
	COV_COUNT_WR: cover property (WR && ADDR == `TMR_COUNT);
endmodule
bind tmr_top tmr_monitor u_mon (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.RD(RD), .RDATA(RDATA), .FLAG_ACK(FLAG_ACK), .FLAGS(FLAGS), .OC_A(OC_A),
	.OC_A_OE_N(OC_A_OE_N), .OC_B(OC_B), .OC_B_OE_N(OC_B_OE_N));
`default_nettype wire

// file: tb/tmr_load.sv
// Purpose: external load on a compare pin
// Assumes: pull-down on the node
// Notes: measures period and high time between rising edges
`timescale 1ns/1ns
`default_nettype none
module tmr_load (
	// pin side
	input wire logic clk,
	input wire logic drv,
	input wire logic oe_n,
	// measurements
	output logic level,
	output int period,
	output int high_time
);
	logic prev = 1'b0;
	int since = 0;
	int hi = 0;
	// released pin falls to the pull-down level
	assign level = oe_n ? 1'b0 : drv;
	// restart both counts at each rising edge
	always_ff @(posedge clk) begin
		prev <= level;
		if (level && !prev) begin
			period <= since;
			high_time <= hi;
			since <= 1;
			hi <= 1;
		end else begin
			since <= since + 1;
			hi <= hi + int'(level);
		end
	end
endmodule
`default_nettype wire

// file: tb/tmr_top_tb.sv
// Purpose: self-checking bench of the timer
// Assumes: 250 MHz clock, register map of tmr_regs.svh
// Notes: expected waveforms reckoned from prescale, top and compare
`include "tmr_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tmr_top_tb;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [3:0] ADDR = 4'h0;
	logic [15:0] WDATA = 16'h0;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [3:0] FLAG_ACK = 4'h0;
	logic [15:0] RDATA;
	logic [3:0] FLAGS;
	logic OC_A;
	logic OC_A_OE_N;
	logic OC_B;
	logic OC_B_OE_N;
	logic level;
	int period;
	int high_time;
	logic level_b;
	int period_b;
	int high_b;
	// register image kept from the rules, and the reads still to be checked
	int model[8] = '{default: 0};
	int exp_q[$];
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	int c;
	int top;
	int r;
	int divs[5] = '{1, 8, 64, 256, 1024};
	int tops[3] = '{255, 511, 1023};
	// 4 ns period
	always #2 CLK = ~CLK;
	tmr_top DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .FLAG_ACK(FLAG_ACK), .FLAGS(FLAGS), .OC_A(OC_A),
		.OC_A_OE_N(OC_A_OE_N), .OC_B(OC_B), .OC_B_OE_N(OC_B_OE_N));
	tmr_load LOAD (.clk(CLK), .drv(OC_A), .oe_n(OC_A_OE_N), .level(level),
		.period(period), .high_time(high_time));
	tmr_load LOAD_B (.clk(CLK), .drv(OC_B), .oe_n(OC_B_OE_N), .level(level_b),
		.period(period_b), .high_time(high_b));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	// control holds 11 bits, compares lose the bits above a fixed top
	function automatic void model_write(input int a, input int d);
		int m;
		m = model[0] % 16;
		if (a == 0 || a == 6) begin
			model[a] = a == 0 ? d % 2048 : d % 4;
		end else if (a == 2 || a == 3) begin
			model[a] = (m >= 5 && m <= 7) ? d & tops[m - 5] : d;
		end else if (a != 5) begin
			model[a] = d;
		end
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		model_write(a, d);
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge CLK);
		RD <= 1'b1;
		ADDR <= a;
		exp_q.push_back(model[a]);
		@(posedge CLK);
		RD <= 1'b0;
		#1 cmp16(RDATA, 16'(exp_q.pop_front()));
	endtask
	// stopped while loading, so the count starts cleanly from zero
	task automatic setup(input logic [15:0] ctl, input int cmp, input int cap);
		wr(`TMR_CTRL, ctl & 16'h00ff);
		wr(`TMR_FLAGS, 16'h000f);
		wr(`TMR_COUNT, 16'h0);
		wr(`TMR_CMPA, cmp[15:0]);
		wr(`TMR_CMPB, cmp[15:0]);
		wr(`TMR_CAPTOP, cap[15:0]);
		wr(`TMR_DIR, 16'h0003);
		wr(`TMR_CTRL, ctl);
	endtask
	// four periods: one to settle, the rest to measure
	task automatic wave(input int p, input int h);
		repeat (4 * p + 8) @(posedge CLK);
		#1 cmp16(period[15:0], p[15:0]);
		cmp16(high_time[15:0], h[15:0]);
	endtask
	// hang guard
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(93033));
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		for (int i = 0; i < 8; i++) rd(i[3:0]);
		$display("reset values done");
		r = $urandom;
		wr(`TMR_COUNT, r[15:0]);
		rd(`TMR_COUNT);
		for (int m = 0; m < 3; m++) begin
			wr(`TMR_CTRL, 16'(m + 5));
			wr(`TMR_CMPA, r[15:0]);
			rd(`TMR_CMPA);
		end
		$display("register writes done");
		wr(`TMR_CTRL, 16'h0000);
		wr(`TMR_COUNT, 16'hfffe);
		wr(`TMR_FLAGS, 16'h000f);
		wr(`TMR_CTRL, 16'h0100);
		repeat (4) @(posedge CLK);
		#1 cmp16({15'h0, FLAGS[0]}, 16'h1);
		@(posedge CLK);
		FLAG_ACK <= 4'h1;
		@(posedge CLK);
		FLAG_ACK <= 4'h0;
		@(posedge CLK);
		#1 cmp16({15'h0, FLAGS[0]}, 16'h0);
		$display("overflow done");
		for (int p = 0; p < 5; p++) begin
			c = $urandom % 2;
			setup(16'h0014 | 16'(p + 1) << 8, c, 0);
			wave(2 * divs[p] * (1 + c), divs[p] * (1 + c));
		end
		cmp16({15'h0, FLAGS[1]}, 16'h1);
		$display("clear on match done");
		for (int m = 0; m < 6; m++) begin
			c = m == 0 ? 0 : $urandom % 20;
			setup(16'h0100 | 16'(m % 3 + 5) | (m < 3 ? 16'h00a0 : 16'h00f0), c, 0);
			wave(tops[m % 3] + 1, m < 3 ? c + 1 : tops[m % 3] - c);
			cmp16(period_b[15:0], 16'(tops[m % 3] + 1));
			cmp16(high_b[15:0], 16'(m < 3 ? c + 1 : tops[m % 3] - c));
		end
		top = 3 + $urandom % 30;
		c = $urandom % top;
		setup(16'h012e, c, top);
		wave(top + 1, c + 1);
		cmp16({15'h0, FLAGS[3]}, 16'h1);
		top = 3 + $urandom % 30;
		setup(16'h011f, top, 0);
		wave(2 * (top + 1), top + 1);
		$display("fast pwm done");
		give_verdict();
	end
endmodule
`default_nettype wire
